//--- qhs_pkg.sv
// Shared constants and carrier types for the quad serial host port block
`default_nettype none

package qhs_pkg;

  localparam int NUM_CH       = 4;
  localparam int DATA_W       = 8;
  localparam int FIFO_DEPTH   = 64;
  localparam int ADDR_W       = 8;
  localparam int ADDR_TOP_BIT = 7;
  localparam int CH_SEL_HI    = 5;
  localparam int CH_SEL_LO    = 4;

  // Channel register offsets on address bits 3..0
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_MCR  = 4'h4;
  localparam logic [3:0] OFS_MSR  = 4'h6;
  localparam logic [3:0] OFS_FEATURE_CONTROL_REG = 4'h8;

  // Device configuration register addresses
  localparam logic [7:0] OFS_INT0      = 8'h80;
  localparam logic [7:0] OFS_INT1      = 8'h81;
  localparam logic [7:0] OFS_INT2      = 8'h82;
  localparam logic [7:0] OFS_INT3      = 8'h83;
  localparam logic [7:0] OFS_TMR_CTL   = 8'h84;
  localparam logic [7:0] OFS_TMR_LSB   = 8'h85;
  localparam logic [7:0] OFS_TMR_MSB   = 8'h86;
  localparam logic [7:0] OFS_SW_RESET  = 8'h8a;
  localparam logic [7:0] OFS_GLOBAL_WR = 8'h8b;

  // Field positions
  localparam int MCR_DTR_BIT    = 0;
  localparam int MCR_RTS_BIT    = 1;
  localparam int MCR_IR_BIT     = 6;
  localparam int MCR_PRESC_BIT  = 7;
  localparam int FEATURE_CONTROL_REG_RXPOL_BIT = 4;
  localparam int GW_ALL_BIT     = 0;
  localparam int TMR_EN_BIT     = 0;
  localparam int TMR_EXT_BIT    = 1;

  // Values after reset
  localparam logic [7:0]  MCR_RST        = 8'h00;
  localparam logic [7:0]  FEATURE_CONTROL_REG_RST       = 8'h00;
  localparam logic [7:0]  GLOBAL_WR_RST  = 8'h00;
  localparam logic [7:0]  TMR_CTL_RST    = 8'h00;
  localparam logic [15:0] TMR_RELOAD_RST = 16'hffff;

  // Divide-by-4 prescaler wraps after this count
  localparam logic [1:0] PRESC_DIV4_LAST = 2'h3;

  // Hardware reset pulse: a least time, rounded up, never below one cycle
  localparam int CLK_PERIOD_NS = 40;
  localparam int RST_PULSE_NS  = 40;
  localparam int RST_PULSE_RAW = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC = (RST_PULSE_RAW < 1) ? 1 : RST_PULSE_RAW;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] addr;
    logic [7:0] wdata;
  } qhs_bus_s;

  typedef struct packed {
    logic [3:0] cd_n;
    logic [3:0] ri_n;
    logic [3:0] cts_n;
    logic [3:0] dsr_n;
  } qhs_modem_s;

endpackage

`default_nettype wire

//--- qhs_fifo.sv
// Byte FIFO used for each channel's transmit and receive queue
`default_nettype none

module qhs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 64
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  output logic      [W-1:0] pop_data,
  output logic              not_empty,
  output logic              full
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW:0]             wp;
    logic [PW:0]             rp;
  } qhs_fifo_state_s;

  qhs_fifo_state_s s;
  qhs_fifo_state_s n;

  assign full      = (s.wp[PW] != s.rp[PW]) && (s.wp[PW-1:0] == s.rp[PW-1:0]);
  assign not_empty = (s.wp != s.rp);
  assign pop_data  = s.mem[s.rp[PW-1:0]];

  always_comb begin
    n = s;
    // A push into a full queue is dropped rather than overwriting the head
    if (push && !full) begin
      n.mem[s.wp[PW-1:0]] = push_data;
      n.wp                = s.wp + (PW+1)'(1);
    end
    if (pop && not_empty) begin
      n.rp = s.rp + (PW+1)'(1);
    end
    // Memory contents are left alone on reset; only the pointers matter
    if (rst) begin
      n.wp = '0;
      n.rp = '0;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fifo_full_holds;
    full && push && !pop |=> full && $stable(s.wp);
  endproperty
  a_fifo_full_holds: assert property (p_fifo_full_holds)
    else $error("Push into full queue changed it");

  property p_fifo_depth;
    (s.wp - s.rp) <= (PW+1)'(DEPTH);
  endproperty
  a_fifo_depth: assert property (p_fifo_depth)
    else $error("Queue occupancy exceeds its depth");

endmodule

`default_nettype wire

//--- qhs_top.sv
// Quad serial controller host port: channel select, resets, strap and pin idle logic
`default_nettype none


module qhs_top (
  input  wire logic            REF_CLK,
  input  wire logic            SYS_RST,
  input  wire logic            HW_RESET_N,
  input  wire logic            BUS_STYLE_SEL,
  input  wire logic            CS_N,
  input  wire logic            READ_STROBE_N,
  input  wire logic            WRITE_STROBE_N,
  input  wire logic [7:0]      ADDR,
  input  wire logic [7:0]      DATA_IN,
  output logic      [7:0]      DATA_OUT,
  output logic                 DATA_OE_N,
  input  wire logic            INFRARED_BOOT_STRAP,
  input  wire logic            TIMER_EXT_CLOCK,
  input  wire logic [3:0]      SERIAL_IN,
  output logic      [3:0]      SERIAL_OUT,
  output logic      [3:0]      RX_MARK,
  output logic      [3:0]      PRESCALE_TICK,
  output logic      [3:0]      REQUEST_SEND_OUT_N,
  output logic      [3:0]      TERMINAL_READY_OUT_N,
  input  wire logic [3:0]      CLEAR_SEND_IN_N,
  input  wire logic [3:0]      SET_READY_IN_N,
  input  wire logic [3:0]      CARRIER_DETECT_IN_N,
  input  wire logic [3:0]      RING_INDICATOR_IN_N,
  output logic      [3:0][7:0] TX_FIFO_DATA,
  output logic      [3:0]      TX_FIFO_VALID,
  input  wire logic [3:0]      TX_FIFO_POP,
  input  wire logic [3:0][7:0] RX_FIFO_DATA_IN,
  input  wire logic [3:0]      RX_FIFO_PUSH,
  output logic      [3:0]      RX_FIFO_FULL
);

  typedef struct packed {
    qhs_pkg::qhs_bus_s   bus1;
    qhs_pkg::qhs_bus_s   bus2;
    qhs_pkg::qhs_modem_s mdm1;
    qhs_pkg::qhs_modem_s mdm2;
    logic [1:0]          strap;
    logic [1:0]          style;
    logic [1:0]          hwrst;
    logic [2:0]          timer_ext_clock;
    logic [3:0]          rx1;
    logic [3:0]          rx2;
    logic [1:0]          hw_cnt;
    logic                rd_prev;
    logic                wr_prev;
    logic [3:0][7:0]     modem_control_reg;
    logic [3:0][7:0]     feature_control_reg;
    logic [7:0]          gw;
    logic [7:0]          tmr_ctl;
    logic [15:0]         tmr_reload;
    logic [15:0]         tmr_cnt;
    logic                tmr_done;
    logic [3:0][1:0]     presc;
    logic [3:0]          presc_tick;
    logic [3:0]          sout;
    logic [3:0]          rx_mark;
    logic [3:0]          rts_n;
    logic [3:0]          dtr_n;
    logic [3:0]          fifo_rst;
    logic [7:0]          rdata;
    logic                rd_act;
  } qhs_state_s;

  qhs_state_s s;
  qhs_state_s n;

  // One-hot channel from an address; reserved space selects none
  function automatic logic [3:0] ch_onehot(input logic [7:0] a);
    ch_onehot = 4'h0;
    if (!a[qhs_pkg::ADDR_TOP_BIT]) begin
      ch_onehot[a[qhs_pkg::CH_SEL_HI:qhs_pkg::CH_SEL_LO]] = 1'b1;
    end
  endfunction

  logic             style_first;
  logic             rd_cond;
  logic             wr_cond;
  logic             rd_start;
  logic             wr_start;
  logic             hw_act;
  logic [3:0]       wr_tgt;
  logic [3:0]       tx_push;
  logic [3:0]       rx_pop;
  logic [3:0]       tx_full;
  logic [3:0][7:0]  rx_head;
  logic [3:0]       rx_ne;
  logic             tmr_tick;
  logic [3:0]       rd_sel;

  assign style_first = s.style[1];
  // Second style: write strobe pin is read/not-write, chip select times the access
  assign rd_cond  = !s.bus2.cs_n && (style_first ? !s.bus2.rd_n : s.bus2.wr_n);
  assign wr_cond  = !s.bus2.cs_n && !s.bus2.wr_n;
  assign rd_start = rd_cond && !s.rd_prev;
  assign wr_start = wr_cond && !s.wr_prev;
  assign hw_act   = (32'(s.hw_cnt) >= qhs_pkg::RST_PULSE_CYC);
  assign rd_sel   = ch_onehot(s.bus2.addr);
  // Broadcast ignores the channel bits but never reaches reserved space
  assign wr_tgt   = (s.gw[qhs_pkg::GW_ALL_BIT] && !s.bus2.addr[qhs_pkg::ADDR_TOP_BIT]) ?
                    4'hf : ch_onehot(s.bus2.addr);
  assign tmr_tick = s.tmr_ctl[qhs_pkg::TMR_EXT_BIT] ? (s.timer_ext_clock[1] && !s.timer_ext_clock[2]) : 1'b1;

  genvar g;
  generate
    for (g = 0; g < qhs_pkg::NUM_CH; g++) begin : g_ch
      assign tx_push[g] = wr_start && wr_tgt[g] && (s.bus2.addr[3:0] == qhs_pkg::OFS_DATA);
      assign rx_pop[g]  = rd_start && rd_sel[g] && (s.bus2.addr[3:0] == qhs_pkg::OFS_DATA);
      qhs_fifo #(.W(qhs_pkg::DATA_W), .DEPTH(qhs_pkg::FIFO_DEPTH)) u_tx_fifo (
        .clk       (REF_CLK),
        .rst       (s.fifo_rst[g] || SYS_RST),
        .push      (tx_push[g]),
        .push_data (s.bus2.wdata),
        .pop       (TX_FIFO_POP[g]),
        .pop_data  (TX_FIFO_DATA[g]),
        .not_empty (TX_FIFO_VALID[g]),
        .full      (tx_full[g])
      );
      qhs_fifo #(.W(qhs_pkg::DATA_W), .DEPTH(qhs_pkg::FIFO_DEPTH)) u_rx_fifo (
        .clk       (REF_CLK),
        .rst       (s.fifo_rst[g] || SYS_RST),
        .push      (RX_FIFO_PUSH[g]),
        .push_data (RX_FIFO_DATA_IN[g]),
        .pop       (rx_pop[g]),
        .pop_data  (rx_head[g]),
        .not_empty (rx_ne[g]),
        .full      (RX_FIFO_FULL[g])
      );
    end
  endgenerate

  always_comb begin
    logic [3:0] ch_rst;
    logic [1:0] idx;
    ch_rst = 4'h0;
    idx    = s.bus2.addr[qhs_pkg::CH_SEL_HI:qhs_pkg::CH_SEL_LO];
    n = s;
    // Two flip-flop synchronisers for every pin from outside the clock domain
    n.bus1  = '{cs_n: CS_N, rd_n: READ_STROBE_N, wr_n: WRITE_STROBE_N,
                addr: ADDR, wdata: DATA_IN};
    n.bus2  = s.bus1;
    n.mdm1  = '{cd_n: CARRIER_DETECT_IN_N, ri_n: RING_INDICATOR_IN_N,
                cts_n: CLEAR_SEND_IN_N, dsr_n: SET_READY_IN_N};
    n.mdm2  = s.mdm1;
    n.strap = {s.strap[0], INFRARED_BOOT_STRAP};
    n.style = {s.style[0], BUS_STYLE_SEL};
    n.hwrst = {s.hwrst[0], HW_RESET_N};
    n.timer_ext_clock = {s.timer_ext_clock[1:0], TIMER_EXT_CLOCK};
    n.rx1   = SERIAL_IN;
    n.rx2   = s.rx1;
    n.rd_prev = rd_cond;
    n.wr_prev = wr_cond;
    n.rd_act  = rd_cond;
    // Low time on the reset pin is counted so a glitch shorter than the pulse is ignored
    if (s.hwrst[1]) begin
      n.hw_cnt = 2'h0;
    end else if (s.hw_cnt != 2'h3) begin
      n.hw_cnt = s.hw_cnt + 2'h1;
    end

    // Register writes
    if (wr_start) begin
      for (int c = 0; c < qhs_pkg::NUM_CH; c++) begin
        if (wr_tgt[c]) begin
          case (s.bus2.addr[3:0])
            qhs_pkg::OFS_MCR:  n.modem_control_reg[c]  = s.bus2.wdata;
            qhs_pkg::OFS_FEATURE_CONTROL_REG: n.feature_control_reg[c] = s.bus2.wdata;
            default:           n.modem_control_reg[c]  = n.modem_control_reg[c];
          endcase
        end
      end
      case (s.bus2.addr)
        qhs_pkg::OFS_TMR_CTL:   n.tmr_ctl = s.bus2.wdata;
        qhs_pkg::OFS_TMR_LSB:   n.tmr_reload[7:0] = s.bus2.wdata;
        qhs_pkg::OFS_TMR_MSB: begin
          n.tmr_reload[15:8] = s.bus2.wdata;
          n.tmr_cnt          = {s.bus2.wdata, s.tmr_reload[7:0]};
        end
        qhs_pkg::OFS_GLOBAL_WR: n.gw = s.bus2.wdata;
        qhs_pkg::OFS_SW_RESET:  ch_rst = s.bus2.wdata[3:0];
        default:                n.gw = n.gw;
      endcase
    end

    // Register reads; data is captured at the start of the access
    if (rd_start) begin
      if (s.bus2.addr[qhs_pkg::ADDR_TOP_BIT]) begin
        case (s.bus2.addr)
          qhs_pkg::OFS_INT0:      n.rdata = {3'h0, s.tmr_done, rx_ne};
          qhs_pkg::OFS_INT1:      n.rdata = {4'h0, ~TX_FIFO_VALID};
          qhs_pkg::OFS_INT2:      n.rdata = {4'h0, ~s.mdm2.cts_n};
          qhs_pkg::OFS_INT3:      n.rdata = {7'h00, s.tmr_done};
          qhs_pkg::OFS_TMR_CTL:   n.rdata = s.tmr_ctl;
          qhs_pkg::OFS_TMR_LSB:   n.rdata = s.tmr_cnt[7:0];
          qhs_pkg::OFS_TMR_MSB:   n.rdata = s.tmr_cnt[15:8];
          qhs_pkg::OFS_GLOBAL_WR: n.rdata = s.gw;
          default:                n.rdata = 8'h00;
        endcase
        // Reading the first source register acknowledges the timer event
        if (s.bus2.addr == qhs_pkg::OFS_INT0) begin
          n.tmr_done = 1'b0;
        end
      end else begin
        case (s.bus2.addr[3:0])
          qhs_pkg::OFS_DATA: n.rdata = rx_ne[idx] ? rx_head[idx] : 8'h00;
          qhs_pkg::OFS_MCR:  n.rdata = s.modem_control_reg[idx];
          qhs_pkg::OFS_MSR:  n.rdata = {~s.mdm2.cd_n[idx], ~s.mdm2.ri_n[idx],
                                        ~s.mdm2.dsr_n[idx], ~s.mdm2.cts_n[idx], 4'h0};
          qhs_pkg::OFS_FEATURE_CONTROL_REG: n.rdata = s.feature_control_reg[idx];
          default:           n.rdata = 8'h00;
        endcase
      end
    end

    // Timer: down counter with reload; its event wins over an acknowledge
    if (s.tmr_ctl[qhs_pkg::TMR_EN_BIT] && tmr_tick) begin
      if (s.tmr_cnt == 16'h0000) begin
        n.tmr_cnt  = s.tmr_reload;
        n.tmr_done = 1'b1;
      end else begin
        n.tmr_cnt = s.tmr_cnt - 16'h0001;
      end
    end

    // Whole-device resets
    if (SYS_RST || hw_act) begin
      ch_rst     = 4'hf;
      n.gw       = qhs_pkg::GLOBAL_WR_RST;
      n.tmr_ctl  = qhs_pkg::TMR_CTL_RST;
      n.tmr_reload = qhs_pkg::TMR_RELOAD_RST;
      n.tmr_cnt  = qhs_pkg::TMR_RELOAD_RST;
      n.tmr_done = 1'b0;
    end
    n.fifo_rst = ch_rst;

    for (int c = 0; c < qhs_pkg::NUM_CH; c++) begin
      if (ch_rst[c]) begin
        n.modem_control_reg[c]  = qhs_pkg::MCR_RST;
        n.feature_control_reg[c] = qhs_pkg::FEATURE_CONTROL_REG_RST;
        n.presc[c] = 2'h0;
        // Strap is re-sampled on every reset so all channels can boot in infrared
        n.modem_control_reg[c][qhs_pkg::MCR_IR_BIT] = s.strap[1];
      end else if (s.modem_control_reg[c][qhs_pkg::MCR_PRESC_BIT]) begin
        n.presc[c] = (s.presc[c] == qhs_pkg::PRESC_DIV4_LAST) ? 2'h0 : s.presc[c] + 2'h1;
      end else begin
        n.presc[c] = 2'h0;
      end
      n.presc_tick[c] = !ch_rst[c] && (!s.modem_control_reg[c][qhs_pkg::MCR_PRESC_BIT] ||
                        s.presc[c] == qhs_pkg::PRESC_DIV4_LAST);
      // Idle level only; the shifter that would drive data here is not in this block
      n.sout[c]  = !n.modem_control_reg[c][qhs_pkg::MCR_IR_BIT];
      n.rts_n[c] = !n.modem_control_reg[c][qhs_pkg::MCR_RTS_BIT];
      n.dtr_n[c] = !n.modem_control_reg[c][qhs_pkg::MCR_DTR_BIT];
      if (!s.modem_control_reg[c][qhs_pkg::MCR_IR_BIT]) begin
        n.rx_mark[c] = s.rx2[c];
      end else begin
        // Either setting of the polarity bit takes a low level as mark
        n.rx_mark[c] = !s.rx2[c];
      end
    end

    if (SYS_RST) begin
      n.hw_cnt  = 2'h0;
      n.rd_prev = 1'b0;
      n.wr_prev = 1'b0;
      n.rd_act  = 1'b0;
      n.rdata   = 8'h00;
    end
  end

  always_ff @(posedge REF_CLK) begin
    s <= n;
  end

  assign DATA_OUT             = s.rdata;
  assign DATA_OE_N            = !s.rd_act;
  assign SERIAL_OUT           = s.sout;
  assign RX_MARK              = s.rx_mark;
  assign PRESCALE_TICK        = s.presc_tick;
  assign REQUEST_SEND_OUT_N   = s.rts_n;
  assign TERMINAL_READY_OUT_N = s.dtr_n;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  property p_tx_idle;
    ##1 (SERIAL_OUT[0] == !s.modem_control_reg[0][qhs_pkg::MCR_IR_BIT]);
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("Transmit idle level does not match mode");

  property p_ir_polarity;
    s.modem_control_reg[1][qhs_pkg::MCR_IR_BIT] && !s.feature_control_reg[1][qhs_pkg::FEATURE_CONTROL_REG_RXPOL_BIT] && !s.rx2[1]
      && !hw_act && !wr_start |=> RX_MARK[1];
  endproperty
  a_ir_polarity: assert property (p_ir_polarity)
    else $error("Low receive level not taken as mark");

  property p_strap_copy;
    hw_act ##1 !hw_act |-> s.modem_control_reg[2][qhs_pkg::MCR_IR_BIT] == $past(s.strap[1], 1);
  endproperty
  a_strap_copy: assert property (p_strap_copy)
    else $error("Strap level not copied at reset");

  property p_hw_reset;
    hw_act |=> s.gw == qhs_pkg::GLOBAL_WR_RST && s.feature_control_reg == '0 ##1
      REQUEST_SEND_OUT_N == 4'hf && TERMINAL_READY_OUT_N == 4'hf;
  endproperty
  a_hw_reset: assert property (p_hw_reset)
    else $error("Hardware reset left state not at default");

  property p_sw_reset;
    wr_start && s.bus2.addr == qhs_pkg::OFS_SW_RESET && s.bus2.wdata[3] |=>
      s.modem_control_reg[3][qhs_pkg::MCR_RTS_BIT] == 1'b0 && s.feature_control_reg[3] == qhs_pkg::FEATURE_CONTROL_REG_RST;
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("Software reset missed the chosen channel");

  property p_style_read;
    !style_first && !s.bus2.cs_n && s.bus2.wr_n |=> !DATA_OE_N;
  endproperty
  a_style_read: assert property (p_style_read)
    else $error("Second bus style read not answered");

  property p_ch_decode;
    wr_start && !hw_act && s.gw == 8'h00 && s.bus2.addr == 8'h24 |=>
      s.modem_control_reg[2] == $past(s.bus2.wdata) && $stable(s.modem_control_reg[0]);
  endproperty
  a_ch_decode: assert property (p_ch_decode)
    else $error("Channel decode wrote the wrong channel");

  property p_timer_ext;
    s.tmr_ctl == 8'h03 && s.timer_ext_clock[1] && !s.timer_ext_clock[2] && s.tmr_cnt != 16'h0000
      && !wr_start && !hw_act |=> s.tmr_cnt == $past(s.tmr_cnt) - 16'h0001;
  endproperty
  a_timer_ext: assert property (p_timer_ext)
    else $error("External timer clock edge not counted");

  property p_int_src;
    rd_start && s.bus2.addr == qhs_pkg::OFS_INT0 |=> DATA_OUT[3:0] == $past(rx_ne);
  endproperty
  a_int_src: assert property (p_int_src)
    else $error("Interrupt source register wrong");

  property p_presc_div4;
    PRESCALE_TICK[0] && s.modem_control_reg[0][qhs_pkg::MCR_PRESC_BIT] && !wr_start && !hw_act
      |=> (!PRESCALE_TICK[0] || !$past(s.modem_control_reg[0][qhs_pkg::MCR_PRESC_BIT])) [*3];
  endproperty
  a_presc_div4: assert property (p_presc_div4)
    else $error("Divide by 4 prescaler ticked too soon");

  property p_msr_inputs;
    rd_start && s.bus2.addr == 8'h36 |=> DATA_OUT[4] == !$past(s.mdm2.cts_n[3]);
  endproperty
  a_msr_inputs: assert property (p_msr_inputs)
    else $error("Active low input not reported as set");

  property p_broadcast;
    wr_start && !hw_act && s.gw[0] && !s.bus2.addr[qhs_pkg::ADDR_TOP_BIT]
      && s.bus2.addr[3:0] == qhs_pkg::OFS_MCR |=>
      s.modem_control_reg[0] == s.modem_control_reg[3] && s.modem_control_reg[1] == $past(s.bus2.wdata);
  endproperty
  a_broadcast: assert property (p_broadcast)
    else $error("Global write did not reach all channels");

  property p_cs_idle;
    s.bus2.cs_n && !hw_act |=> $stable(s.gw) && $stable(s.feature_control_reg) && DATA_OE_N;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("Access taken while chip select high");

endmodule

`default_nettype wire

//--- qhs_host_model.sv
// Host processor model that drives the parallel register port pins
`default_nettype none

module qhs_host_model (
  input  wire logic       clk,
  input  wire logic       style_first,
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_oe_n,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] addr,
  output logic      [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // Pins pass a 2FF sync, so address and data settle 3 cycles before the strobe
  task automatic access(input logic is_rd, input logic sel, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_n  <= style_first | is_rd;
    repeat (3) @(posedge clk);
    cs_n <= ~sel;
    rd_n <= ~(style_first & is_rd);
    wr_n <= is_rd;
    repeat (8) begin
      @(posedge clk);
      if (is_rd && rdata_oe_n === 1'b0) begin
        q = rdata;
        break;
      end
    end
    cs_n  <= 1'b1;
    rd_n  <= 1'b1;
    wr_n  <= 1'b1;
    // Released lines do not keep the old value
    addr  <= ~a;
    wdata <= ~d;
    repeat (4) @(posedge clk);
  endtask
endmodule

`default_nettype wire

//--- quad_uart_host_select_reset_test.sv
// Self-checking bench for the quad serial host port block
`default_nettype none

module quad_uart_host_select_reset_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk    = 1'b0;
  logic            rst    = 1'b1;
  logic            hw_n   = 1'b1;
  logic            style  = 1'b1;
  logic            strap  = 1'b0;
  logic      [3:0] ser_in = 4'hf;
  logic      [3:0] cts_n  = 4'hf;
  logic      [3:0] mdm_n  = 4'hf;
  logic            tmr_ck = 1'b0;
  wire logic       cs_n, rd_n, wr_n, oe_n;
  wire logic [7:0] addr, wdata, dout;
  wire logic [3:0] ser_out, rx_mark, tick, rts_n, dtr_n;
  int              error_cnt = 0;
  int              n_tests   = 0;

  always #20 clk = ~clk;

  qhs_host_model u_host (.clk(clk), .style_first(style), .rdata(dout), .rdata_oe_n(oe_n),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata));

  qhs_top u_dut (.REF_CLK(clk), .SYS_RST(rst), .HW_RESET_N(hw_n), .BUS_STYLE_SEL(style),
    .CS_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .ADDR(addr), .DATA_IN(wdata),
    .DATA_OUT(dout), .DATA_OE_N(oe_n), .INFRARED_BOOT_STRAP(strap), .TIMER_EXT_CLOCK(tmr_ck),
    .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .RX_MARK(rx_mark), .PRESCALE_TICK(tick),
    .REQUEST_SEND_OUT_N(rts_n), .TERMINAL_READY_OUT_N(dtr_n), .CLEAR_SEND_IN_N(cts_n),
    .SET_READY_IN_N(mdm_n), .CARRIER_DETECT_IN_N(mdm_n), .RING_INDICATOR_IN_N(mdm_n),
    .TX_FIFO_DATA(), .TX_FIFO_VALID(), .TX_FIFO_POP(4'h0), .RX_FIFO_DATA_IN('0),
    .RX_FIFO_PUSH(4'h0), .RX_FIFO_FULL());

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string s, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.access(1'b0, 1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    u_host.access(1'b1, 1'b1, a, 8'h00, q);
  endtask

  task automatic t_decode();
    logic [7:0] q;
    chk("idle", {4'h0, ser_out}, 8'h0f);
    chk("rts", {4'h0, rts_n}, 8'h0f);
    chk("oe", {7'h0, oe_n}, 8'h01);
    for (int ch = 0; ch < 4; ch++) begin
      wr({2'b00, 2'(ch), 4'h4}, 8'h03);
      chk("rts", {4'h0, rts_n}, 8'(~(4'h1 << ch) & 4'hf));
      chk("dtr", {4'h0, dtr_n}, 8'(~(4'h1 << ch) & 4'hf));
      wr({2'b00, 2'(ch), 4'h4}, 8'h00);
    end
    wr(8'hb4, 8'h03);
    chk("rsvd", {4'h0, rts_n}, 8'h0f);
    u_host.access(1'b0, 1'b0, 8'h04, 8'h03, q);
    chk("nocs", {4'h0, rts_n}, 8'h0f);
    $display("test decode done");
  endtask

  task automatic t_infra();
    wr(8'h14, 8'h40);
    chk("irout", {4'h0, ser_out}, 8'h0d);
    ser_in[1] <= 1'b0;
    cyc(6);
    chk("mark0", {7'h0, rx_mark[1]}, 8'h01);
    wr(8'h18, 8'h10);
    ser_in[1] <= 1'b1;
    cyc(6);
    chk("space1", {7'h0, rx_mark[1]}, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h14, 8'h00);
    $display("test infrared done");
  endtask

  task automatic t_global();
    logic [7:0] q;
    wr(8'h8b, 8'h01);
    wr(8'h24, 8'h02);
    chk("bcast", {4'h0, rts_n}, 8'h00);
    wr(8'h8b, 8'h00);
    wr(8'h20, 8'h5a);
    rd(8'h81, q);
    chk("txempty", q, 8'h0b);
    wr(8'h8a, 8'h05);
    chk("swrst", {4'h0, rts_n}, 8'h05);
    rd(8'h81, q);
    chk("txflush", q, 8'h0f);
    wr(8'h8a, 8'h0f);
    chk("swrst", {4'h0, rts_n}, 8'h0f);
    $display("test global done");
  endtask

  task automatic t_style();
    logic [7:0] q;
    cts_n[3] <= 1'b0;
    mdm_n[3] <= 1'b0;
    rd(8'h36, q);
    chk("status", q & 8'hf0, 8'hf0);
    style <= 1'b0;
    cyc(4);
    rd(8'h36, q);
    chk("status2", q & 8'hf0, 8'hf0);
    wr(8'h04, 8'h01);
    chk("dtr2", {4'h0, dtr_n}, 8'h0e);
    wr(8'h04, 8'h00);
    style <= 1'b1;
    cts_n <= 4'hf;
    mdm_n <= 4'hf;
    cyc(4);
    $display("test style done");
  endtask

  task automatic t_presc();
    int c0;
    int c1;
    c0 = 0;
    c1 = 0;
    wr(8'h04, 8'h80);
    repeat (16) begin
      @(posedge clk);
      c0 += int'(tick[0] === 1'b1);
      c1 += int'(tick[1] === 1'b1);
    end
    chk("div4", c0[7:0], 8'h04);
    chk("div1", c1[7:0], 8'h10);
    wr(8'h04, 8'h00);
    $display("test prescale done");
  endtask

  task automatic t_timer();
    logic [7:0] q;
    wr(8'h85, 8'h02);
    wr(8'h86, 8'h00);
    wr(8'h84, 8'h03);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        rd(8'h85, q);
        chk("tcount", q, 8'h00);
      end
      tmr_ck <= 1'b1;
      cyc(3);
      tmr_ck <= 1'b0;
      cyc(3);
    end
    rd(8'h83, q);
    chk("tdone", q, 8'h01);
    rd(8'h80, q);
    chk("int0", q, 8'h10);
    rd(8'h83, q);
    chk("tack", q, 8'h00);
    wr(8'h84, 8'h00);
    $display("test timer done");
  endtask

  task automatic t_resets();
    wr(8'h04, 8'h03);
    strap <= 1'b1;
    hw_n  <= 1'b0;
    cyc(3);
    hw_n <= 1'b1;
    cyc(8);
    chk("irboot", {4'h0, ser_out}, 8'h00);
    chk("hwrts", {4'h0, rts_n}, 8'h0f);
    strap <= 1'b0;
    wr(8'h8a, 8'h02);
    chk("irsoft", {4'h0, ser_out}, 8'h02);
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    cyc(3);
    chk("sysrst", {4'h0, ser_out}, 8'h0f);
    $display("test resets done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // About 40 accesses of some 16 cycles each; the limit leaves ample margin
  initial begin
    cyc(6000);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(3);
    t_decode();
    t_infra();
    t_global();
    t_style();
    t_presc();
    t_timer();
    t_resets();
    tally_and_finish();
  end
endmodule

`default_nettype wire
